// >>> core/sbcs_top.sv
// System bus control and status registers with request, arbitration and burst logic
`timescale 1ns/1ps
module sbcs_top
    import sbcs_pkg::*;
#(
    // Arbitrary value
    parameter logic [REV_W-1:0] REVISION = 8'h01
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire sbcs_req_t req_i,
    output logic [DW-1:0] rdata_o,
    // Direct transfer bus request
    input wire logic ddt_pending_i,
    input wire logic bus_available_in_n_i,
    output logic bus_request_out_n_o,
    // Polygon input unit arbitration
    input wire logic poly_req_i,
    input wire logic root_req_i,
    output logic poly_grant_o,
    output logic root_grant_o,
    // Texture path DMA bursts
    input wire logic tex_dma_busy_i,
    input wire logic [FREE_W-1:0] fifo_free_i,
    output logic tex_beat_o,
    output logic tex_burst_end_o,
    // Texture write width
    input wire logic [AW-1:0] tex_wr_addr_i,
    output logic texture_write_width_main_o,
    output logic texture_write_width_mirror_o,
    output logic tex_wr_32bit_o,
    // FIFO status, reset, split
    input wire logic [FFST_W-1:0] fifo_not_empty_i,
    output logic sys_reset_o,
    output logic root_bus_split_o,
    // Interrupt sources
    input wire sbcs_irq_t irq_i
);
    // -----------------------------------------
    // Register storage
    // -----------------------------------------
    logic req_mask;
    logic [WAIT_W-1:0] wait_cfg;
    logic [PRIO_W-1:0] prio_cfg;
    logic [BURST_W-1:0] burst_cfg;
    logic [NRM_W-1:0] nrm;
    logic [NRM_W-1:0] next_nrm;
    logic [DW-1:0] nrm_word;
    logic [DW-1:0] next_rdata;
    logic key_hit;
    logic nrm_wr;

    function automatic logic hit(input logic [AW-1:0] ofs);
        hit = req_i.addr == ofs;
    endfunction

    assign key_hit = req_i.wr && hit(OFS_SWRST) && req_i.wdata == SWRST_KEY;
    assign nrm_wr = req_i.wr && hit(OFS_NRM);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            req_mask <= 1'b0;
            wait_cfg <= WAIT_RST;
            prio_cfg <= PRIO_RST;
            burst_cfg <= BURST_RST;
            texture_write_width_main_o <= 1'b0;
            texture_write_width_mirror_o <= 1'b0;
            root_bus_split_o <= 1'b0;
        end else if (ce_i && req_i.wr) begin
            if (hit(OFS_REQ_MASK)) begin
                req_mask <= req_i.wdata[0];
            end
            if (hit(OFS_WAIT)) begin
                wait_cfg <= req_i.wdata[WAIT_W-1:0];
            end
            if (hit(OFS_PRIO)) begin
                prio_cfg <= req_i.wdata[PRIO_W-1:0];
            end
            // Taken as written even mid-transfer; software keeps it still then
            if (hit(OFS_BURST)) begin
                burst_cfg <= req_i.wdata[BURST_W-1:0];
            end
            if (hit(OFS_WMAIN)) begin
                texture_write_width_main_o <= req_i.wdata[0];
            end
            if (hit(OFS_WMIRR)) begin
                texture_write_width_mirror_o <= req_i.wdata[0];
            end
            if (hit(OFS_SPLIT)) begin
                root_bus_split_o <= req_i.wdata[SPLIT_BIT];
            end
        end
    end

    // -----------------------------------------
    // Keyed software reset
    // -----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b0;
        end else if (ce_i) begin
            sys_reset_o <= key_hit;
        end
    end

    // -----------------------------------------
    // Normal interrupt status
    // -----------------------------------------
    // A new event in the clearing cycle survives the clear
    always_comb begin
        next_nrm = nrm;
        if (nrm_wr) begin
            next_nrm = nrm & ~req_i.wdata[NRM_W-1:0];
        end
        next_nrm = next_nrm | irq_i.nrm;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nrm <= NRM_RST;
        end else if (ce_i) begin
            nrm <= next_nrm;
        end
    end

    always_comb begin
        nrm_word = '0;
        nrm_word[NRM_W-1:0] = nrm;
        nrm_word[ERR_OR_BIT] = |irq_i.err;
        nrm_word[EXT_OR_BIT] = |irq_i.ext;
    end

    // -----------------------------------------
    // Read path
    // -----------------------------------------
    always_comb begin
        next_rdata = '0;
        case (req_i.addr)
            OFS_REQ_MASK: next_rdata[0] = req_mask;
            OFS_WAIT: next_rdata[WAIT_W-1:0] = wait_cfg;
            OFS_PRIO: next_rdata[PRIO_W-1:0] = prio_cfg;
            OFS_BURST: next_rdata[BURST_W-1:0] = burst_cfg;
            OFS_FREE: next_rdata[FREE_W-1:0] = fifo_free_i;
            OFS_WMAIN: next_rdata[0] = texture_write_width_main_o;
            OFS_WMIRR: next_rdata[0] = texture_write_width_mirror_o;
            OFS_FFST: next_rdata[FFST_W-1:0] = fifo_not_empty_i;
            OFS_REV: next_rdata[REV_W-1:0] = REVISION;
            OFS_SPLIT: next_rdata[SPLIT_BIT] = root_bus_split_o;
            OFS_NRM: next_rdata = nrm_word;
            OFS_EXT: next_rdata[EXT_W-1:0] = irq_i.ext;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (ce_i && req_i.rd) begin
            rdata_o <= next_rdata;
        end
    end

    // -----------------------------------------
    // Direct transfer bus request
    // -----------------------------------------
    logic [WAIT_W:0] wait_cnt;
    logic [WAIT_W:0] wait_lim;
    logic req_due;
    logic waiting;

    assign wait_lim = (wait_cfg == WAIT_RST) ? WAIT_ZERO_CNT : {1'b0, wait_cfg};
    assign waiting = ddt_pending_i && bus_available_in_n_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wait_cnt <= '0;
            req_due <= 1'b0;
        end else if (ce_i) begin
            if (!waiting) begin
                wait_cnt <= '0;
                req_due <= 1'b0;
            end else if (wait_cnt + 6'h01 >= wait_lim) begin
                req_due <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 6'h01;
            end
        end
    end

    // Masking stretches direct transfers a long way
    assign bus_request_out_n_o = !(req_due && !req_mask);

    // -----------------------------------------
    // Polygon path arbitration
    // -----------------------------------------
    logic [PRIO_W:0] poly_cnt;
    logic [PRIO_W:0] prio_lim;
    logic root_turn;

    assign prio_lim = (prio_cfg == PRIO_RST) ? PRIO_ZERO_CNT : {1'b0, prio_cfg};
    assign root_turn = root_req_i && (poly_cnt >= prio_lim || !poly_req_i);
    assign root_grant_o = ce_i && root_turn;
    assign poly_grant_o = ce_i && poly_req_i && !root_turn;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            poly_cnt <= '0;
        end else if (root_grant_o) begin
            poly_cnt <= '0;
        end else if (poly_grant_o && poly_cnt < prio_lim) begin
            poly_cnt <= poly_cnt + 5'h01;
        end
    end

    // -----------------------------------------
    // Texture path DMA bursts
    // -----------------------------------------
    sbcs_burst_t bstate;
    logic [BEAT_W-1:0] beat_cnt;
    logic [BEAT_W-1:0] beat_lim;
    logic fifo_full;
    logic last_beat;

    always_comb begin
        case (burst_cfg)
            BURST_SEL_1K: beat_lim = BEATS_1K;
            BURST_SEL_256: beat_lim = BEATS_256;
            // The forbidden code falls back to the shortest burst
            default: beat_lim = BEATS_128;
        endcase
    end

    assign fifo_full = fifo_free_i == FREE_NONE;
    assign tex_beat_o = ce_i && bstate == SBCS_BURST && !fifo_full;
    assign last_beat = beat_cnt + 6'h01 >= beat_lim;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bstate <= SBCS_IDLE;
            beat_cnt <= '0;
            tex_burst_end_o <= 1'b0;
        end else if (ce_i) begin
            tex_burst_end_o <= 1'b0;
            case (bstate)
                SBCS_IDLE: begin
                    beat_cnt <= '0;
                    if (tex_dma_busy_i && !fifo_full) begin
                        bstate <= SBCS_BURST;
                    end
                end
                SBCS_BURST: begin
                    if (!tex_dma_busy_i || fifo_full) begin
                        bstate <= SBCS_IDLE;
                        tex_burst_end_o <= 1'b1;
                    end else if (last_beat) begin
                        bstate <= SBCS_IDLE;
                        tex_burst_end_o <= 1'b1;
                    end else begin
                        beat_cnt <= beat_cnt + 6'h01;
                    end
                end
                default: bstate <= SBCS_IDLE;
            endcase
        end
    end

    // -----------------------------------------
    // Texture write width select
    // -----------------------------------------
    always_comb begin
        case (tex_wr_addr_i[AW-1:AW-8])
            AREA_MAIN: tex_wr_32bit_o = texture_write_width_main_o;
            AREA_MIRR: tex_wr_32bit_o = texture_write_width_mirror_o;
            default: tex_wr_32bit_o = 1'b0;
        endcase
    end

    // -----------------------------------------
    // Checks
    // -----------------------------------------
    property p_mask;
        @(posedge ref_clk_i) disable iff (rst_i)
        req_mask |-> bus_request_out_n_o;
    endproperty
    a_mask: assert property (p_mask) else $error("request not masked");

    property p_wait;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && waiting && !req_mask && !(req_i.wr && req_i.addr == OFS_REQ_MASK)
            && wait_cnt + 6'h01 >= wait_lim) |=> !bus_request_out_n_o;
    endproperty
    a_wait: assert property (p_wait) else $error("request late");

    property p_early;
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(bus_request_out_n_o) |-> $past(wait_cnt) + 6'h01 >= $past(wait_lim);
    endproperty
    a_early: assert property (p_early) else $error("request early");

    property p_arb;
        @(posedge ref_clk_i) disable iff (rst_i)
        (root_grant_o && poly_req_i) |-> poly_cnt >= prio_lim && !poly_grant_o;
    endproperty
    a_arb: assert property (p_arb) else $error("root granted early");

    property p_blen;
        @(posedge ref_clk_i) disable iff (rst_i)
        bstate == SBCS_BURST |-> beat_cnt < beat_lim;
    endproperty
    a_blen: assert property (p_blen) else $error("burst too long");

    property p_full;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && bstate == SBCS_BURST && fifo_full) |=> bstate == SBCS_IDLE && tex_burst_end_o;
    endproperty
    a_full: assert property (p_full) else $error("burst not ended");

    property p_pause;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && bstate == SBCS_IDLE && fifo_full) |=> bstate == SBCS_IDLE && !tex_beat_o;
    endproperty
    a_pause: assert property (p_pause) else $error("beat without space");

    property p_free;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && req_i.rd && req_i.addr == OFS_FREE) |=> rdata_o[FREE_W-1:0] == $past(fifo_free_i);
    endproperty
    a_free: assert property (p_free) else $error("free space wrong");

    property p_key;
        @(posedge ref_clk_i) disable iff (rst_i)
        sys_reset_o |-> $past(key_hit) && $past(ce_i);
    endproperty
    a_key: assert property (p_key) else $error("reset without key");

    property p_set;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && |irq_i.nrm) |=> (nrm & $past(irq_i.nrm)) == $past(irq_i.nrm);
    endproperty
    a_set: assert property (p_set) else $error("event lost");

    property p_keep;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && nrm_wr) |=> (nrm & ~$past(req_i.wdata[NRM_W-1:0]))
            == (($past(nrm) | $past(irq_i.nrm)) & ~$past(req_i.wdata[NRM_W-1:0]));
    endproperty
    a_keep: assert property (p_keep) else $error("zero write changed bit");
endmodule

// >>> core/sbcs_pkg.sv
// Constants and carrier types for the system bus control and status block
//
// Functional notes
// - Mask setting 1 holds the bus request output inactive.
// - Count clocks awaiting bus-available; on expiry assert bus request.
// - Wait count 1..31 means N clocks; 0 means 32, the default.
// - Grant polygon DMA N times per root-bus request; 0 means 16.
// - Burst field: 1 gives 128 bytes, 2 gives 256, 0 gives 1024.
// - Burst ends early when the polygon FIFO fills.
// - No FIFO space pauses texture DMA; with space it bursts full length.
// - Free-space register reports FIFO space in 32-byte units, 0 to 8.
// - Main width bit picks 64-bit (0) or 32-bit (1) direct texture writes.
// - Mirror width bit does the same for the mirror area.
// - FIFO status bits read 1 when the FIFO or request is not empty.
// - Writing the reset key starts a whole-system reset.
// - Any other value written to the reset register is ignored.
// - Eight-bit read-only revision in the low bits of the revision register.
// - Split bit 31: 0 single write burst, 1 single write split.
// - Normal status bits 21..0 are sticky, write-one-to-clear, reset to 0.
// - Bit 31 ORs pending errors, bit 30 ORs external; writes ignored.
// - Bit 19 texture DMA end, 20 sorted DMA end, 5..0 video events.
// - External status reads four external request lines directly.
package sbcs_pkg;
    localparam int unsigned AW = 32;
    localparam int unsigned DW = 32;
    localparam int unsigned NRM_W = 22;
    localparam int unsigned EXT_W = 4;
    localparam int unsigned ERR_W = 32;
    localparam int unsigned FFST_W = 6;
    localparam int unsigned WAIT_W = 5;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned BURST_W = 2;
    localparam int unsigned FREE_W = 4;
    localparam int unsigned REV_W = 8;
    localparam int unsigned BEAT_W = 6;
    localparam int unsigned ERR_OR_BIT = 31;
    localparam int unsigned EXT_OR_BIT = 30;
    localparam int unsigned SPLIT_BIT = 31;
    // Register byte addresses
    localparam logic [AW-1:0] OFS_REQ_MASK = 32'h005F6840;
    localparam logic [AW-1:0] OFS_WAIT = 32'h005F6844;
    localparam logic [AW-1:0] OFS_PRIO = 32'h005F6848;
    localparam logic [AW-1:0] OFS_BURST = 32'h005F684C;
    localparam logic [AW-1:0] OFS_FREE = 32'h005F6880;
    localparam logic [AW-1:0] OFS_WMAIN = 32'h005F6884;
    localparam logic [AW-1:0] OFS_WMIRR = 32'h005F6888;
    localparam logic [AW-1:0] OFS_FFST = 32'h005F688C;
    localparam logic [AW-1:0] OFS_SWRST = 32'h005F6890;
    localparam logic [AW-1:0] OFS_REV = 32'h005F689C;
    localparam logic [AW-1:0] OFS_SPLIT = 32'h005F68A0;
    localparam logic [AW-1:0] OFS_NRM = 32'h005F6900;
    localparam logic [AW-1:0] OFS_EXT = 32'h005F6904;
    // Reset values and keys
    localparam logic [WAIT_W-1:0] WAIT_RST = 5'h00;
    localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h1;
    localparam logic [NRM_W-1:0] NRM_RST = 22'h000000;
    localparam logic [DW-1:0] SWRST_KEY = 32'h00007611;
    // A zero field stands for one past its largest value
    localparam logic [WAIT_W:0] WAIT_ZERO_CNT = 6'h20;
    localparam logic [PRIO_W:0] PRIO_ZERO_CNT = 5'h10;
    // Burst sizes in 32-byte FIFO units
    localparam logic [BURST_W-1:0] BURST_SEL_1K = 2'h0;
    localparam logic [BURST_W-1:0] BURST_SEL_256 = 2'h2;
    localparam logic [BEAT_W-1:0] BEATS_128 = 6'h04;
    localparam logic [BEAT_W-1:0] BEATS_256 = 6'h08;
    localparam logic [BEAT_W-1:0] BEATS_1K = 6'h20;
    localparam logic [FREE_W-1:0] FREE_NONE = 4'h0;
    // Direct texture areas, top byte of the address
    localparam logic [7:0] AREA_MAIN = 8'h11;
    localparam logic [7:0] AREA_MIRR = 8'h13;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } sbcs_req_t;

    typedef struct packed {
        logic [ERR_W-1:0] err;
        logic [EXT_W-1:0] ext;
        logic [NRM_W-1:0] nrm;
    } sbcs_irq_t;

    typedef enum logic {
        SBCS_IDLE,
        SBCS_BURST
    } sbcs_burst_t;
endpackage

// >>> tb/sbcs_host_model.sv
// Host side model: answers the bus request with bus-available after a set latency
`timescale 1ns/1ps
module sbcs_host_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Answer latency in cycles, zero never answers
    input wire logic [7:0] lat_i,
    // Bus handshake
    input wire logic bus_request_out_n_i,
    output logic bus_available_in_n_o
);
    logic [7:0] cnt;

    // ----------------------------------------
    // Bus-available answer
    // ----------------------------------------
    // A zero latency plays a busy host, so the request timer must expire on its own
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || bus_request_out_n_i || lat_i == 8'h00) begin
            cnt <= 8'h00;
            bus_available_in_n_o <= 1'b1;
        end else if (cnt == lat_i) begin
            bus_available_in_n_o <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// >>> tb/system_bus_control_status_tb.sv
// Self-checking bench for the system bus control and status block
`timescale 1ns/1ps
module system_bus_control_status_tb;
    import sbcs_pkg::*;
    // Arbitrary revision value
    localparam logic [REV_W-1:0] REV_SET = 8'h5A;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    sbcs_req_t req = '0;
    sbcs_irq_t irq = '0;
    logic [DW-1:0] rdata;
    logic ddt_pend = 1'b0, bus_available_in_n_n, breq_n, poly_req = 1'b0, root_req = 1'b0, poly_gnt, root_gnt;
    logic busy = 1'b0, beat, bend, w_main, w_mirr, w32, sysrst, split, rst_seen;
    logic [FREE_W-1:0] free = 4'h8;
    logic [AW-1:0] taddr = '0;
    logic [FFST_W-1:0] ffst = '0;
    logic [NRM_W-1:0] pat;
    logic [7:0] lat = 8'h00;
    logic ce = 1'b1;
    logic [31:0] seed = 32'hCC1B;
    int bad_count = 0;
    int num_checks = 0;
    int n;
    int m;
    int k;
    int lims[4] = '{1, 7, 31, 0};
    int prios[3] = '{1, 3, 0};
    int bsel[3] = '{1, 2, 0};
    int bexp[3] = '{4, 8, 32};

    always #12.5 ref_clk_i = ~ref_clk_i;

    sbcs_top #(.REVISION(REV_SET)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .req_i(req), .rdata_o(rdata),
        .ddt_pending_i(ddt_pend), .bus_available_in_n_i(bus_available_in_n_n), .bus_request_out_n_o(breq_n),
        .poly_req_i(poly_req), .root_req_i(root_req), .poly_grant_o(poly_gnt), .root_grant_o(root_gnt),
        .tex_dma_busy_i(busy), .fifo_free_i(free), .tex_beat_o(beat), .tex_burst_end_o(bend),
        .tex_wr_addr_i(taddr), .texture_write_width_main_o(w_main), .texture_write_width_mirror_o(w_mirr),
        .tex_wr_32bit_o(w32), .fifo_not_empty_i(ffst), .sys_reset_o(sysrst), .root_bus_split_o(split),
        .irq_i(irq)
    );

    sbcs_host_model host_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .lat_i(lat),
        .bus_request_out_n_i(breq_n), .bus_available_in_n_o(bus_available_in_n_n)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick(input int c = 1);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One access, then an idle cycle so strobes never toggle twice in a step
    task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [DW-1:0] q);
        req.wr = w;
        req.rd = !w;
        req.addr = a;
        req.wdata = d;
        tick();
        q = rdata;
        rst_seen = sysrst;
        req = '0;
        tick();
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic [DW-1:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] q;
        acc(1'b0, a, '0, q);
        chk(nm, exp, q);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(3);
        rst_i = 1'b0;
        rchk("wait_rst", OFS_WAIT, 32'h0);
        rchk("prio_rst", OFS_PRIO, 32'h0);
        rchk("burst_rst", OFS_BURST, 32'h1);
        rchk("wmain_rst", OFS_WMAIN, 32'h0);
        rchk("wmirr_rst", OFS_WMIRR, 32'h0);
        rchk("split_rst", OFS_SPLIT, 32'h0);
        rchk("nrm_rst", OFS_NRM, 32'h0);
        rchk("rev", OFS_REV, {24'h0, REV_SET});
        rchk("unmapped", 32'h005F6850, 32'h0);
        // A write while the enable is low must leave the register alone
        ce = 1'b0;
        wr(OFS_WAIT, 32'h0000_0005);
        ce = 1'b1;
        rchk("ce_freeze", OFS_WAIT, 32'h0);
        for (k = 0; k < 8; k++) begin
            free = 4'(rnd() % 9);
            ffst = FFST_W'(rnd());
            irq.ext = EXT_W'(rnd());
            irq.err = k[0] ? rnd() : '0;
            wr(OFS_FREE, 32'hFFFF_FFFF);
            rchk("free", OFS_FREE, {28'h0, free});
            rchk("ffst", OFS_FFST, {26'h0, ffst});
            rchk("ext", OFS_EXT, {28'h0, irq.ext});
            rchk("nrm_or", OFS_NRM, {|irq.err, |irq.ext, 30'h0});
            wr(OFS_SWRST, rnd() | 32'h0001_0000);
            chk("nokey", 1'b0, rst_seen);
        end
        irq = '0;
        pat = NRM_W'(rnd()) | 22'h18003F;
        irq.nrm = pat;
        tick();
        irq.nrm = '0;
        rchk("nrm_set", OFS_NRM, {10'h0, pat});
        wr(OFS_NRM, 32'hC000_0000);
        rchk("nrm_keep", OFS_NRM, {10'h0, pat});
        wr(OFS_NRM, 32'h0008_0000);
        rchk("nrm_clr", OFS_NRM, {10'h0, pat & ~22'h080000});
        wr(OFS_NRM, 32'h003F_FFFF);
        rchk("nrm_all", OFS_NRM, 32'h0);
        // Event and clear of the same bit in one cycle: the event wins
        req.wr = 1'b1;
        req.addr = OFS_NRM;
        req.wdata = 32'h0000_0008;
        irq.nrm = 22'h000008;
        tick();
        req = '0;
        irq.nrm = '0;
        tick();
        rchk("nrm_setwin", OFS_NRM, 32'h0000_0008);
        wr(OFS_NRM, 32'h003F_FFFF);
        for (k = 0; k < 4; k++) begin
            wr(OFS_WMAIN, {31'h0, k[0]});
            wr(OFS_WMIRR, {31'h0, k[1]});
            rchk("wmain", OFS_WMAIN, {31'h0, k[0]});
            chk("w_main", k[0], w_main);
            chk("w_mirr", k[1], w_mirr);
            taddr = {AREA_MAIN, 24'(rnd())};
            tick();
            chk("w32_main", k[0], w32);
            taddr = {AREA_MIRR, 24'(rnd())};
            tick();
            chk("w32_mirr", k[1], w32);
            taddr = 32'h1200_0000;
            tick();
            chk("w32_other", 1'b0, w32);
        end
        wr(OFS_SPLIT, 32'hFFFF_FFFF);
        chk("split", 1'b1, split);
        rchk("split_rd", OFS_SPLIT, 32'h8000_0000);
        foreach (lims[i]) begin
            wr(OFS_WAIT, lims[i]);
            ddt_pend = 1'b1;
            n = 0;
            do begin
                tick();
                n++;
            end while (breq_n !== 1'b0 && n < 40);
            chk("breq_wait", (lims[i] == 0) ? 32 : lims[i], n);
            if (n == 40) final_report();
            lat = 8'h02;
            n = 0;
            do begin
                tick();
                n++;
            end while (breq_n !== 1'b1 && n < 10);
            chk("breq_release", 1'b1, breq_n);
            if (n == 10) final_report();
            ddt_pend = 1'b0;
            lat = 8'h00;
            tick(2);
        end
        wr(OFS_REQ_MASK, 32'h1);
        ddt_pend = 1'b1;
        n = 0;
        repeat (40) begin
            tick();
            n += (breq_n !== 1'b1);
        end
        chk("mask", 0, n);
        ddt_pend = 1'b0;
        wr(OFS_REQ_MASK, 32'h0);
        foreach (prios[i]) begin
            wr(OFS_PRIO, prios[i]);
            poly_req = 1'b1;
            root_req = 1'b1;
            n = 0;
            m = 0;
            repeat (60) begin
                tick();
                if (root_gnt === 1'b1) begin
                    if (m > 0) chk("poly_per_root", (prios[i] == 0) ? 16 : prios[i], n);
                    m++;
                    n = 0;
                end else begin
                    n += (poly_gnt === 1'b1);
                end
            end
            chk("roots_seen", 1'b1, m > 1);
            poly_req = 1'b0;
            root_req = 1'b0;
        end
        foreach (bsel[i]) begin
            wr(OFS_BURST, bsel[i]);
            free = 4'h8;
            busy = 1'b1;
            n = 0;
            for (k = 0; k < 60; k++) begin
                tick();
                if (bend === 1'b1) break;
                n += (beat === 1'b1);
            end
            chk("burst_beats", bexp[i], n);
            if (k == 60) final_report();
            busy = 1'b0;
            tick(3);
        end
        wr(OFS_BURST, 32'h0);
        busy = 1'b1;
        tick(3);
        free = FREE_NONE;
        n = 0;
        m = 0;
        repeat (12) begin
            tick();
            n += (beat === 1'b1);
            m += (bend === 1'b1);
        end
        chk("full_beats", 0, n);
        chk("full_end", 1, m);
        free = 4'h3;
        n = 0;
        repeat (3) begin
            tick();
            n += (beat === 1'b1);
        end
        chk("resume", 1'b1, n > 0);
        busy = 1'b0;
        tick(3);
        wr(OFS_SWRST, SWRST_KEY);
        chk("key_pulse", 1'b1, rst_seen);
        chk("key_end", 1'b0, sysrst);
        final_report();
    end
endmodule
